// [hw/msc_pkg.sv]
// Purpose: shared constants for the module sideband control ends
// Assumes: 50 MHz system clock on both ends
// Notes:   times are kept in their own unit; counts derive from them
`default_nettype none
package msc_pkg;
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
   // least low time on the reset pin that counts as a reset
   localparam int unsigned RESET_MIN_NS   = 10_000;
   localparam int unsigned RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest reset completion interval
   localparam int unsigned INIT_MS        = 2000;
   localparam int unsigned INIT_CYC       = (INIT_MS * 1000) / CLK_PERIOD_NS * 1000;
   // host holds its reset pulse a little over the least time
   localparam int unsigned HOST_HOLD_CYC  = RESET_MIN_CYC + 2;
   localparam int unsigned CNT_W          = 32;
   localparam logic        PIN_IDLE_HIGH  = 1'b1;
   localparam logic        PRESENT_LEVEL  = 1'b0;
endpackage
`default_nettype wire

// [hw/msc_if.sv]
// Purpose: pins between the host board and the pluggable module
// Assumes: open-collector lines resolved here from drive enables
// Notes:   board pull-ups modelled as the idle level of each line
`timescale 1ns/1ps
`default_nettype none
interface msc_if;
   logic select_o;
   logic select_oe;
   logic module_select_n;
   logic module_reset_n;
   logic low_power_select;
   logic module_present_n;
   logic int_o;
   logic int_oe;
   logic interrupt_out_n;
   logic mod_sda_o;
   logic mod_sda_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic sda;

   // undriven select reads high: module stays deselected
   assign module_select_n = select_oe ? select_o : 1'b1;
   // module only pulls low; host board supplies the pull-up
   assign interrupt_out_n = (int_oe && !int_o) ? 1'b0 : 1'b1;
   assign sda = !((mod_sda_oe && !mod_sda_o) || (host_sda_oe && !host_sda_o));

   modport module_end (
      input  module_select_n,
      input  module_reset_n,
      input  low_power_select,
      input  sda,
      output module_present_n,
      output int_o,
      output int_oe,
      output mod_sda_o,
      output mod_sda_oe
   );
   modport host_end (
      output select_o,
      output select_oe,
      output module_reset_n,
      output low_power_select,
      output host_sda_o,
      output host_sda_oe,
      input  module_present_n,
      input  interrupt_out_n,
      input  sda
   );
endinterface
`default_nettype wire

// [hw/msc_module_end.sv]
// Purpose: module-side sideband control: select gating, reset, interrupt
// Assumes: 2-wire engine and memory map live outside, on clk_sys_in
// Notes:   pins pass two flip-flops before any logic reads them
// Functional notes
// R1: selected module answers 2-wire commands
// R2: deselected module never drives the data line
// R3: host selects only one module per bus
// R4: select input pulled up, idle deselected
// R5: long reset low restores all settings
// R6: completion timing starts at reset release
// R7: host ignores status during completion interval; host end revalidates on any low interrupt line after its pulse
// R8: completion shown as interrupt, not-ready cleared
// R9: power-up posts completion interrupt unprompted
// R10: low-power pin high gives reduced power
// R11: presence output held low while inserted
// R12: interrupt line pulled low on faults
// R13: host reads cause over 2-wire bus
// R14: host board pulls interrupt line up
// R15: host reads flag field after interrupt
// R16: short reset pulses are ignored entirely
`timescale 1ns/1ps
`default_nettype none
module msc_module_end #(
   parameter int unsigned RESET_MIN = msc_pkg::RESET_MIN_CYC,
   parameter int unsigned INIT_TIME = msc_pkg::INIT_CYC
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   msc_if.module_end pins,
   input  wire logic eng_sda_o_in,
   input  wire logic eng_sda_oe_in,
   input  wire logic fault_event_in,
   input  wire logic int_clear_in,
   output logic      bus_selected_out,
   output logic      sda_sampled_out,
   output logic      settings_default_out,
   output logic      data_not_ready_out,
   output logic      low_power_out,
   output logic      int_pending_out
);
   import msc_pkg::*;

   // the completion counter reaches its last value at count minus one
   if (RESET_MIN < 1 || INIT_TIME < 1) begin : g_bad_counts
      $error("msc_module_end: counts must be at least one cycle");
   end

   typedef enum logic [1:0] {
      MSC_ST_INIT = 2'b00,
      MSC_ST_RUN  = 2'b01,
      MSC_ST_HELD = 2'b10
   } msc_state_t;

   localparam logic [CNT_W-1:0] RESET_MIN_W = CNT_W'(RESET_MIN);
   localparam logic [CNT_W-1:0] INIT_LAST_W = CNT_W'(INIT_TIME - 1);

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic sel_meta;
   logic sel_sync;
   logic rst_meta;
   logic rst_sync;
   logic lp_meta;
   logic lp_sync;
   logic sda_meta;
   logic sda_sync;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         // deselected until the pin says otherwise
         sel_meta <= PIN_IDLE_HIGH; // see R4
         sel_sync <= PIN_IDLE_HIGH; // see R4
         rst_meta <= PIN_IDLE_HIGH;
         rst_sync <= PIN_IDLE_HIGH;
         lp_meta  <= 1'b0;
         lp_sync  <= 1'b0;
         sda_meta <= PIN_IDLE_HIGH;
         sda_sync <= PIN_IDLE_HIGH;
      end else begin
         sel_meta <= pins.module_select_n;
         sel_sync <= sel_meta;
         rst_meta <= pins.module_reset_n;
         rst_sync <= rst_meta;
         lp_meta  <= pins.low_power_select;
         lp_sync  <= lp_meta;
         sda_meta <= pins.sda;
         sda_sync <= sda_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // 2-wire gating by module select
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         bus_selected_out <= 1'b0;
         sda_sampled_out  <= 1'b1;
         pins.mod_sda_o   <= 1'b1;
         pins.mod_sda_oe  <= 1'b0;
      end else begin
         bus_selected_out <= !sel_sync; // see R1
         // deselected engine sees an idle bus, so it never acks
         sda_sampled_out  <= sel_sync ? 1'b1 : sda_sync; // see R2
         pins.mod_sda_o   <= eng_sda_o_in;
         pins.mod_sda_oe  <= eng_sda_oe_in && !sel_sync; // see R1 R2
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reset pulse filter and completion timer
   msc_state_t             state;
   logic [CNT_W-1:0]       low_cnt;
   logic [CNT_W-1:0]       init_cnt;
   logic                   long_low;
   logic                   init_done;

   assign long_low  = (low_cnt >= RESET_MIN_W);
   assign init_done = (state == MSC_ST_INIT) && (init_cnt == INIT_LAST_W);

   // saturating low-time counter; a short low leaves no trace
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         low_cnt <= '0;
      end else if (rst_sync) begin
         low_cnt <= '0; // see R16
      end else if (!long_low) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   // power-up enters the completion interval with no host pulse
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state <= MSC_ST_INIT; // see R9
      end else begin
         unique case (state)
            MSC_ST_INIT,
            MSC_ST_RUN: begin
               if (!rst_sync && long_low) begin
                  state <= MSC_ST_HELD; // see R5
               end else if (init_done) begin
                  state <= MSC_ST_RUN;
               end
            end
            MSC_ST_HELD: begin
               if (rst_sync) begin
                  state <= MSC_ST_INIT; // see R6
               end
            end
            default: begin
               state <= MSC_ST_INIT;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         init_cnt <= '0;
      end else if (state != MSC_ST_INIT) begin
         init_cnt <= '0; // see R6
      end else if (!init_done) begin
         init_cnt <= init_cnt + 1'b1;
      end
   end

   // one-cycle pulse the moment a low becomes long enough
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         settings_default_out <= 1'b1;
      end else begin
         settings_default_out <= (state != MSC_ST_HELD) && !rst_sync && long_low; // see R5
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         data_not_ready_out <= 1'b1;
      end else if (state == MSC_ST_HELD || (state == MSC_ST_INIT && !init_done)) begin
         data_not_ready_out <= 1'b1;
      end else begin
         data_not_ready_out <= 1'b0; // see R8
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt: completion or fault, set wins over clear
   logic next_int_pending;

   always_comb begin
      next_int_pending = int_pending_out;
      if (init_done || (fault_event_in && state == MSC_ST_RUN)) begin
         next_int_pending = 1'b1; // see R8 R9 R12
      end else if (int_clear_in || state == MSC_ST_HELD) begin
         next_int_pending = 1'b0; // see R5
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         int_pending_out <= 1'b0;
      end else begin
         int_pending_out <= next_int_pending;
      end
   end

   // open collector: only ever pulls low
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pins.int_o  <= 1'b0;
         pins.int_oe <= 1'b0;
      end else begin
         pins.int_o  <= 1'b0;
         // pin and flag move on the same edge, so the host never sees a stale line
         pins.int_oe <= next_int_pending; // see R12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power mode and presence
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         low_power_out <= 1'b0;
      end else begin
         low_power_out <= lp_sync; // see R10
      end
   end

   // grounded inside the module for as long as it is inserted
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pins.module_present_n <= PRESENT_LEVEL; // see R11
      end else begin
         pins.module_present_n <= PRESENT_LEVEL; // see R11
      end
   end
endmodule
`default_nettype wire

// [hw/msc_host_end.sv]
// Purpose: host-side sideband control for one module slot
// Assumes: host 2-wire engine lives outside, on clk_sys_in
// Notes:   status is held invalid through the reset pulse, then until the interrupt line reads low
`timescale 1ns/1ps
`default_nettype none
module msc_host_end #(
   parameter int unsigned HOLD_TIME = msc_pkg::HOST_HOLD_CYC
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   msc_if.host_end   pins,
   input  wire logic select_in,
   input  wire logic reset_req_in,
   input  wire logic low_power_in,
   input  wire logic eng_sda_o_in,
   input  wire logic eng_sda_oe_in,
   input  wire logic flags_read_done_in,
   output logic      present_out,
   output logic      status_valid_out,
   output logic      read_flags_req_out,
   output logic      sda_sampled_out
);
   import msc_pkg::*;

   // a zero hold would wrap the last-count compare
   if (HOLD_TIME < 1) begin : g_bad_hold
      $error("msc_host_end: reset hold must be at least one cycle");
   end

   localparam logic [CNT_W-1:0] HOLD_LAST_W = CNT_W'(HOLD_TIME - 1);

   logic             int_meta;
   logic             int_sync;
   logic             prs_meta;
   logic             prs_sync;
   logic             sda_meta;
   logic             sda_sync;
   logic [CNT_W-1:0] hold_cnt;
   logic             holding;
   logic             read_busy;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         int_meta <= PIN_IDLE_HIGH;
         int_sync <= PIN_IDLE_HIGH;
         prs_meta <= PIN_IDLE_HIGH;
         prs_sync <= PIN_IDLE_HIGH;
         sda_meta <= PIN_IDLE_HIGH;
         sda_sync <= PIN_IDLE_HIGH;
      end else begin
         int_meta <= pins.interrupt_out_n; // see R14
         int_sync <= int_meta;
         prs_meta <= pins.module_present_n;
         prs_sync <= prs_meta;
         sda_meta <= pins.sda;
         sda_sync <= sda_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // drive select low only for the addressed slot
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pins.select_o     <= 1'b0;
         pins.select_oe    <= 1'b0;
         pins.host_sda_o   <= 1'b1;
         pins.host_sda_oe  <= 1'b0;
         pins.low_power_select <= 1'b0;
         sda_sampled_out   <= 1'b1;
         present_out       <= 1'b0;
      end else begin
         // released when not addressed: the module's pull-up deselects it
         pins.select_o     <= 1'b0;
         pins.select_oe    <= select_in; // see R3 R4
         pins.host_sda_o   <= eng_sda_o_in;
         pins.host_sda_oe  <= eng_sda_oe_in;
         pins.low_power_select <= low_power_in;
         sda_sampled_out   <= sda_sync;
         present_out       <= !prs_sync;
      end
   end

   // reset pulse held past the module's least length
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         holding  <= 1'b0;
         hold_cnt <= '0;
      end else if (!holding && reset_req_in) begin
         holding  <= 1'b1;
         hold_cnt <= '0;
      end else if (holding) begin
         hold_cnt <= hold_cnt + 1'b1;
         if (hold_cnt == HOLD_LAST_W) begin
            holding <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pins.module_reset_n <= 1'b1;
      end else begin
         pins.module_reset_n <= !(holding || (!holding && reset_req_in));
      end
   end

   // status ignored from reset until the interrupt line reads low once the pulse ends
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || holding || reset_req_in) begin
         status_valid_out <= 1'b0; // see R7
      end else if (!int_sync) begin
         status_valid_out <= 1'b1;
      end
   end

   // flag field read requested while the line is low, again after each completed read
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         read_busy          <= 1'b0;
         read_flags_req_out <= 1'b0;
      end else begin
         read_flags_req_out <= !int_sync && !read_busy && !holding; // see R13 R15
         if (!int_sync && !read_busy && !holding) begin
            read_busy <= 1'b1;
         end else if (flags_read_done_in) begin
            read_busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [test/msc_chk.sv]
// Purpose: pin checks between the host and module ends
// Assumes: one clock, synchronous active-low reset
// Notes:   reset pin low time is counted here
`timescale 1ns/1ps
`default_nettype none
module msc_chk #(
   parameter int unsigned RESET_MIN = 4,
   parameter int unsigned INIT_TIME = 50
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   input  wire logic select_o,
   input  wire logic select_oe,
   input  wire logic module_select_n,
   input  wire logic module_reset_n,
   input  wire logic module_present_n,
   input  wire logic int_o,
   input  wire logic int_oe,
   input  wire logic interrupt_out_n,
   input  wire logic mod_sda_oe
);
   localparam int LO   = INIT_TIME - 2;
   localparam int LONG = RESET_MIN + 2;
   logic [7:0] low_cnt;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////
   // saturates so a stuck-low pin cannot wrap into a short pulse
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || module_reset_n) begin
         low_cnt <= 8'h00;
      end else if (low_cnt != 8'hff) begin
         low_cnt <= low_cnt + 8'h01;
      end
   end
   AST_DESEL_QUIET: assert property (
      module_select_n [*4] |-> !mod_sda_oe) else $error("data driven while deselected");
   AST_SEL_PULLUP: assert property (
      module_select_n == (select_oe ? select_o : 1'b1)) else $error("select not pulled up");
   AST_PRESENT_LOW: assert property (
      !module_present_n) else $error("presence not low");
   AST_INT_PULL_ONLY: assert property (
      int_oe |-> !int_o) else $error("interrupt driven high");
   AST_INT_LEVEL: assert property (
      interrupt_out_n == !int_oe) else $error("interrupt line level wrong");
   AST_LONG_CLEARS: assert property (
      !module_reset_n && low_cnt == LONG + 4 |-> !int_oe) else $error("long reset kept int");
   AST_DONE_AFTER_RESET: assert property (
      $rose(module_reset_n) && low_cnt >= LONG |-> ##LO !int_oe ##[1:10] int_oe)
      else $error("completion interrupt mistimed after reset");
   AST_DONE_AT_POWERUP: assert property (
      $rose(rst_n_in) |-> ##LO !int_oe ##[1:10] int_oe)
      else $error("completion interrupt mistimed at power-up");
endmodule
`default_nettype wire

// [test/msc_tb.sv]
// Purpose: both ends joined; second pair gets a too-short reset pulse
// Assumes: RESET_MIN 4, INIT_TIME 50 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s exp %b got %b", nm, e, g); \
   end \
end
module tb;
   logic clk_sys_in;
   logic rst_n_in;
   logic sel, lp, rq, rq2, hso, hsoe, mso, msoe, fault, clr, fdone;
   logic m_sel, m_sda, m_def, m_dnr, m_lp, m_int, h_prs, h_val, h_rd, h_sda;
   logic m2_def, m2_int, m2_dnr, h2_prs, h2_val;
   int   n_mismatch = 0;
   int   samples_checked = 0;
   int   cyc = 0;
   int   i;
   msc_if if_a ();
   msc_if if_b ();
   msc_module_end #(.RESET_MIN(4), .INIT_TIME(50)) msc_module_end_i (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pins(if_a.module_end),
      .eng_sda_o_in(mso), .eng_sda_oe_in(msoe), .fault_event_in(fault),
      .int_clear_in(clr), .bus_selected_out(m_sel), .sda_sampled_out(m_sda),
      .settings_default_out(m_def), .data_not_ready_out(m_dnr),
      .low_power_out(m_lp), .int_pending_out(m_int));
   msc_host_end #(.HOLD_TIME(12)) msc_host_end_i (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pins(if_a.host_end),
      .select_in(sel), .reset_req_in(rq), .low_power_in(lp), .eng_sda_o_in(hso),
      .eng_sda_oe_in(hsoe), .flags_read_done_in(fdone), .present_out(h_prs),
      .status_valid_out(h_val), .read_flags_req_out(h_rd), .sda_sampled_out(h_sda));
   msc_module_end #(.RESET_MIN(4), .INIT_TIME(50)) msc_module_end_i2 (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pins(if_b.module_end),
      .eng_sda_o_in(mso), .eng_sda_oe_in(msoe), .fault_event_in(fault),
      .int_clear_in(clr), .bus_selected_out(), .sda_sampled_out(),
      .settings_default_out(m2_def), .data_not_ready_out(m2_dnr),
      .low_power_out(), .int_pending_out(m2_int));
   // hold of 1 gives a 2-cycle pulse, under the module's least reset time
   msc_host_end #(.HOLD_TIME(1)) msc_host_end_i2 (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pins(if_b.host_end),
      .select_in(sel), .reset_req_in(rq2), .low_power_in(lp), .eng_sda_o_in(hso),
      .eng_sda_oe_in(hsoe), .flags_read_done_in(fdone), .present_out(h2_prs),
      .status_valid_out(h2_val), .read_flags_req_out(), .sda_sampled_out());
   msc_chk #(.RESET_MIN(4), .INIT_TIME(50)) msc_chk_i (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .select_o(if_a.select_o),
      .select_oe(if_a.select_oe), .module_select_n(if_a.module_select_n),
      .module_reset_n(if_a.module_reset_n), .module_present_n(if_a.module_present_n),
      .int_o(if_a.int_o), .int_oe(if_a.int_oe), .interrupt_out_n(if_a.interrupt_out_n),
      .mod_sda_oe(if_a.mod_sda_oe));
   ////////////////////////////////////////
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic pulse_done();
      fdone = 1'b1;
      tick(1);
      fdone = 1'b0;
   endtask
   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic t_powerup();
      i = 0;
      while ((m_int !== 1'b1 || m2_int !== 1'b1) && i < 100) begin
         tick(1);
         i++;
      end
      `CHK("power-up int", 1'b1, m_int)
      `CHK("power-up int b", 1'b1, m2_int)
      `CHK("not ready", 1'b0, m_dnr)
      `CHK("int pin", 1'b0, if_a.interrupt_out_n)
      tick(4);
      `CHK("status valid", 1'b1, h_val)
      `CHK("present", 1'b1, h_prs)
      pulse_done();
   endtask
   task automatic t_short();
      rq2 = 1'b1;
      tick(1);
      `CHK("status dropped b", 1'b0, h2_val)
      rq2 = 1'b0;
      for (int k = 0; k < 12; k++) begin
         tick(1);
         `CHK("short defaults", 1'b0, m2_def)
      end
      `CHK("short keeps int", 1'b1, m2_int)
      `CHK("short not ready", 1'b0, m2_dnr)
      `CHK("present b", 1'b1, h2_prs)
   endtask
   task automatic t_select();
      msoe = 1'b1;
      mso = 1'b0;
      hsoe = 1'b1;
      hso = 1'b0;
      tick(6);
      `CHK("desel oe", 1'b0, if_a.mod_sda_oe)
      `CHK("desel sda", 1'b1, m_sda)
      `CHK("desel flag", 1'b0, m_sel)
      hsoe = 1'b0;
      sel = 1'b1;
      // select sync, module drive, then host sda sync: seven edges
      tick(8);
      `CHK("sel pin", 1'b0, if_a.module_select_n)
      `CHK("sel flag", 1'b1, m_sel)
      `CHK("module drives sda", 1'b0, h_sda)
      msoe = 1'b0;
      sel = 1'b0;
   endtask
   task automatic t_lowpower();
      lp = 1'b1;
      tick(5);
      `CHK("low power on", 1'b1, m_lp)
      `CHK("released sel", 1'b0, m_sel)
      lp = 1'b0;
      tick(5);
      `CHK("low power off", 1'b0, m_lp)
   endtask
   task automatic t_fault();
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(1);
      `CHK("cleared", 1'b0, m_int)
      `CHK("released pin", 1'b1, if_a.interrupt_out_n)
      // flags read while the line is high, so the next low asks again
      pulse_done();
      fault = 1'b1;
      tick(1);
      fault = 1'b0;
      `CHK("fault int", 1'b1, m_int)
      i = 0;
      while (h_rd !== 1'b1 && i < 10) begin
         tick(1);
         i++;
      end
      `CHK("flag read req", 1'b1, h_rd)
      pulse_done();
   endtask
   task automatic t_long();
      logic d;
      d = 1'b0;
      rq = 1'b1;
      tick(1);
      rq = 1'b0;
      tick(1);
      i = 0;
      while (if_a.module_reset_n !== 1'b1 && i < 40) begin
         tick(1);
         i++;
         if (m_def === 1'b1) d = 1'b1;
      end
      `CHK("defaults", 1'b1, d)
      `CHK("not ready set", 1'b1, m_dnr)
      `CHK("status held", 1'b0, h_val)
      `CHK("int dropped", 1'b0, m_int)
      i = 0;
      while (m_int !== 1'b1 && i < 100) begin
         tick(1);
         i++;
      end
      `CHK("init time", 1'b1, (i >= 50 && i <= 58))
      `CHK("not ready clear", 1'b0, m_dnr)
      pulse_done();
   endtask
   initial begin
      rst_n_in = 1'b0;
      {sel, lp, rq, rq2, hsoe, msoe, fault, clr, fdone} = 9'h000;
      hso = 1'b1;
      mso = 1'b1;
      tick(2);
      rst_n_in = 1'b1;
      tick(1);
      `CHK("status early", 1'b0, h_val)
      `CHK("not ready early", 1'b1, m_dnr)
      t_powerup();
      t_short();
      t_select();
      t_lowpower();
      t_fault();
      t_long();
      stop_test();
   end
endmodule
`default_nettype wire
